// ### pkg/async_receive_regs.vh
// constants for the receive request fifo block
// assumes inclusion by bare name from the design files
`ifndef ASYNC_RECEIVE_REGS_VH
`define ASYNC_RECEIVE_REGS_VH

// =====================================================
// widths
`define LEN_W 14
`define CNT_W 15
`define DATA_W 32
`define ENTRY_W 36

// =====================================================
// fifo entry tag layout
`define TAG_LAST 32
`define TAG_ERR 33
`define TAG_CLS_HI 35
`define TAG_CLS_LO 34

// =====================================================
// link packet kinds
`define KIND_REQ 3'h0
`define KIND_PWR 3'h1
`define KIND_PRD 3'h2
`define KIND_RESP 3'h3
`define KIND_PHY 3'h4

// =====================================================
// internal packet classes (low two bits go into the tag)
`define CLS_REQ 3'h0
`define CLS_PWR 3'h1
`define CLS_RESP 3'h2
`define CLS_PRD 3'h3
`define CLS_SID 3'h4
`define CLS_DROP 3'h5

// =====================================================
// header fields and codes
`define TCODE_HI 7
`define TCODE_LO 4
`define TCODE_WR_QUAD 4'h0
`define TCODE_WR_BLOCK 4'h1
`define SRC_HI 31
`define SRC_LO 16
`define OFFHI_HI 15
`define OFFHI_LO 0
`define ACK_HI 31
`define ACK_LO 28
`define ACK_COMPLETE 4'h1
`define ACK_PENDING 4'h2
`define PHYS_LIMIT_HI 16'h0001
`define ERR_MARKER 32'hFFFF_FFFF
`define ZERO_CNT 15'h0000
`define ONE_CNT 15'h0001
`define WI_MAX 2'h3
`define FILL_MARGIN 3

`endif

// ### design/req_fifo_mem.v
// synchronous fifo storage for receive entries
// assumes one clock; caller never pushes when full
module req_fifo_mem #(
	parameter W = 36,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire core_clk,
	input wire rst,
	input wire push,
	input wire [W-1:0] push_data,
	input wire pop,
	output wire [W-1:0] head_data,
	output wire not_empty,
	output wire [AW:0] fill
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] fill_q;

	assign head_data = mem[rd_q];
	assign not_empty = (fill_q != {(AW+1){1'b0}});
	assign fill = fill_q;

	// =====================================================
	// storage array, no reset needed on data
	always @(posedge core_clk) begin
		if (push)
			mem[wr_q] <= push_data;
	end

	// =====================================================
	// pointers and fill level
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			fill_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				fill_q <= fill_q + 1'b1;
			else if (pop && !push)
				fill_q <= fill_q - 1'b1;
		end
	end
endmodule // req_fifo_mem

// ### design/two_slot_buffer.v
// two-entry buffer with valid and ready on both sides
// assumes one clock; all outputs come from flip-flops
module two_slot_buffer #(
	parameter W = 34
) (
	input wire core_clk,
	input wire rst,
	input wire in_valid,
	input wire [W-1:0] in_data,
	output wire in_ready,
	output wire out_valid,
	output wire [W-1:0] out_data,
	input wire out_ready
);
	reg [W-1:0] d0_q;
	reg [W-1:0] d1_q;
	reg v0_q;
	reg v1_q;
	wire push;
	wire pop;

	// ready only needs the second slot free, so a stall loses nothing
	assign in_ready = !v1_q;
	assign out_valid = v0_q;
	assign out_data = d0_q;
	assign push = in_valid && !v1_q;
	assign pop = v0_q && out_ready;

	// =====================================================
	// shift queue of two slots
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			d0_q <= {W{1'b0}};
			d1_q <= {W{1'b0}};
			v0_q <= 1'b0;
			v1_q <= 1'b0;
		end else if (pop) begin
			if (v1_q) begin
				d0_q <= d1_q;
				v1_q <= 1'b0;
			end else begin
				d0_q <= in_data;
				v0_q <= push;
			end
		end else if (push) begin
			if (!v0_q) begin
				d0_q <= in_data;
				v0_q <= 1'b1;
			end else begin
				d1_q <= in_data;
				v1_q <= 1'b1;
			end
		end
	end
endmodule // two_slot_buffer

// ### design/async_receive_request_fifo.v
// receive-side flow control: shared input fifo with link-side space credit
// assumes link stream and dma writer share core_clk; inputs are synchronous
`include "async_receive_regs.vh"

module async_receive_request_fifo #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire core_clk,
	input wire rst,
	input wire run_ctl,
	input wire link_valid,
	input wire link_first,
	input wire link_last,
	input wire [31:0] link_data,
	input wire [2:0] link_kind,
	input wire link_crc_err,
	input wire [3:0] sent_acknowledge_code,
	input wire [2:0] link_speed,
	input wire [15:0] receive_cycle_stamp,
	input wire node_self_identify_phase,
	input wire node_self_identify_accept_en,
	input wire resp_space_ok,
	input wire desc_len_valid,
	input wire [13:0] descriptor_buffer_length,
	input wire space_add_valid,
	input wire [13:0] space_add_len,
	input wire write_fail,
	input wire dma_ready,
	output wire link_ready,
	output reg ack_busy_q,
	output reg phys_req_valid_q,
	output reg [31:0] phys_req_data_q,
	output reg node_self_identify_valid_q,
	output reg [31:0] node_self_identify_data_q,
	output wire dma_valid,
	output wire [31:0] dma_data,
	output wire dma_last,
	output wire dma_err,
	output reg ctx_dead_q,
	output reg unrecoverable_evt_q,
	output reg pkt_done_evt_q,
	output reg resp_conflict_q,
	output reg posted_err_q,
	output reg [15:0] err_src_q,
	output reg [47:0] err_off_q
);
	// link side states, one-hot
	localparam L_DATA = 3'b001;
	localparam L_TRAIL = 3'b010;
	localparam L_DROP = 3'b100;

	reg [2:0] lst_q;
	reg [2:0] lst_d;
	reg [2:0] cls_q;
	reg [`CNT_W-1:0] space_q;
	reg link_ready_q;
	reg crc_q;
	reg [31:0] trailer_q;
	reg push;
	reg [`ENTRY_W-1:0] push_entry;
	reg dec;
	reg busy_d;
	reg [2:0] cls;
	wire accept;
	wire [AW:0] fill;
	wire [`ENTRY_W-1:0] head;
	wire head_valid;
	wire buf_ready;
	wire pop;
	wire head_last;
	wire head_err;
	wire head_req;
	wire [15:0] add_sum;
	wire [15:0] cnt_next;

	// =====================================================
	// functions
	function [2:0] classify;
		input [2:0] kind;
		input phase;
		input sid_en;
		input resp_ok;
		begin
			case (kind)
				`KIND_PWR: classify = `CLS_PWR;
				`KIND_PRD: classify = `CLS_PRD;
				`KIND_RESP: classify = resp_ok ? `CLS_RESP : `CLS_DROP;
				// self-identify only right after bus reset
				`KIND_PHY: classify = !phase ? `CLS_REQ :
					(sid_en ? `CLS_SID : `CLS_DROP);
				default: classify = `CLS_REQ;
			endcase
		end
	endfunction

	function is_write;
		input [31:0] q0;
		begin
			is_write = (q0[`TCODE_HI:`TCODE_LO] == `TCODE_WR_QUAD) ||
				(q0[`TCODE_HI:`TCODE_LO] == `TCODE_WR_BLOCK);
		end
	endfunction

	function [`ENTRY_W-1:0] entry;
		input [2:0] c;
		input err;
		input last;
		input [31:0] d;
		begin
			entry = {c[1:0], err, last, d};
		end
	endfunction

	assign link_ready = link_ready_q;
	assign accept = link_valid && link_ready_q;

	// =====================================================
	// link side: classify and place quadlets
	always @* begin
		lst_d = lst_q;
		push = 1'b0;
		push_entry = {`ENTRY_W{1'b0}};
		dec = 1'b0;
		busy_d = 1'b0;
		cls = link_first ? classify(link_kind, node_self_identify_phase,
			node_self_identify_accept_en, resp_space_ok) : cls_q;
		case (lst_q)
			L_DATA: begin
				if (accept) begin
					if (cls == `CLS_REQ && space_q == `ZERO_CNT) begin
						// no space at all: busy the whole packet
						busy_d = 1'b1;
						// a packet cut by a failure still needs an ending entry
						if (!link_first) begin
							push = 1'b1;
							push_entry = entry(cls, 1'b1, 1'b1, `ERR_MARKER);
						end
						if (!link_last)
							lst_d = L_DROP;
					end else if (cls == `CLS_REQ && space_q == `ONE_CNT) begin
						// last entry spent on a marker, not data
						push = 1'b1;
						dec = 1'b1;
						busy_d = 1'b1;
						push_entry = entry(cls, 1'b1, 1'b1, `ERR_MARKER);
						if (!link_last)
							lst_d = L_DROP;
					end else if (cls == `CLS_REQ || cls == `CLS_PWR ||
							cls == `CLS_RESP) begin
						push = 1'b1;
						dec = (cls == `CLS_REQ);
						push_entry = entry(cls, 1'b0, 1'b0, link_data);
						if (link_last)
							lst_d = L_TRAIL;
					end
				end
			end
			L_TRAIL: begin
				// trailer uses the entry held back for it
				push = 1'b1;
				// a failure just before the trailer must not wrap the counter
				dec = (cls_q == `CLS_REQ) && (space_q != `ZERO_CNT);
				push_entry = entry(cls_q, crc_q, 1'b1, trailer_q);
				lst_d = L_DATA;
			end
			L_DROP: begin
				if (accept && link_last)
					lst_d = L_DATA;
			end
			default: lst_d = L_DATA;
		endcase
	end

	// =====================================================
	// link side registers
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lst_q <= L_DATA;
			cls_q <= `CLS_REQ;
			link_ready_q <= 1'b0;
			crc_q <= 1'b0;
			trailer_q <= 32'h0000_0000;
			ack_busy_q <= 1'b0;
			phys_req_valid_q <= 1'b0;
			phys_req_data_q <= 32'h0000_0000;
			node_self_identify_valid_q <= 1'b0;
			node_self_identify_data_q <= 32'h0000_0000;
		end else begin
			lst_q <= lst_d;
			if (accept && link_first)
				cls_q <= cls;
			// margin of three entries covers the registered ready lag
			link_ready_q <= (fill <= DEPTH - `FILL_MARGIN) && (lst_d != L_TRAIL);
			if (accept && link_last) begin
				crc_q <= link_crc_err;
				trailer_q <= {sent_acknowledge_code, 1'b0, link_speed, 8'h00,
					receive_cycle_stamp};
			end
			ack_busy_q <= busy_d;
			// physical reads are served beside the fifo, but are accepted only while link_ready is high, which tracks the fifo fill
			phys_req_valid_q <= accept && cls == `CLS_PRD && lst_q == L_DATA;
			phys_req_data_q <= link_data;
			node_self_identify_valid_q <= accept && cls == `CLS_SID && lst_q == L_DATA;
			node_self_identify_data_q <= link_data;
		end
	end

	// =====================================================
	// space counter, 15 bits so two full descriptors fit
	wire [14:0] reclaim_len;
	reg reclaim_valid_q;
	reg [14:0] reclaim_q;
	assign reclaim_len = reclaim_valid_q ? reclaim_q : `ZERO_CNT;
	assign add_sum = {2'b00, (desc_len_valid ? descriptor_buffer_length : 14'h0000)}
		+ {2'b00, (space_add_valid ? space_add_len : 14'h0000)}
		+ {1'b0, reclaim_len};
	assign cnt_next = {1'b0, space_q} + add_sum - {15'h0000, dec};

	always @(posedge core_clk or posedge rst) begin
		if (rst)
			space_q <= `ZERO_CNT;
		else if (!run_ctl || write_fail)
			space_q <= `ZERO_CNT;
		else
			space_q <= cnt_next[`CNT_W-1:0];
	end

	// =====================================================
	// fifo and buffer toward the dma writer
	req_fifo_mem #(
		.W(`ENTRY_W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.push(push),
		.push_data(push_entry),
		.pop(pop),
		.head_data(head),
		.not_empty(head_valid),
		.fill(fill)
	);

	// dead context drains straight out of the fifo
	assign pop = head_valid && (ctx_dead_q || buf_ready);
	assign head_last = head[`TAG_LAST];
	assign head_err = head[`TAG_ERR];
	assign head_req = (head[`TAG_CLS_HI:`TAG_CLS_LO] == `CLS_REQ);

	two_slot_buffer #(
		.W(34)
	) u_buf (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(head_valid && !ctx_dead_q),
		.in_data(head[`TAG_ERR:0]),
		.in_ready(buf_ready),
		.out_valid(dma_valid),
		.out_data({dma_err, dma_last, dma_data}),
		.out_ready(dma_ready)
	);

	// =====================================================
	// system side: per-packet count, header capture, dead drain
	reg [14:0] sys_cnt_q;
	reg [1:0] wi_q;
	reg rd_pkt_q;
	reg hold_q;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sys_cnt_q <= `ZERO_CNT;
			wi_q <= 2'h0;
			rd_pkt_q <= 1'b0;
			hold_q <= 1'b0;
			reclaim_valid_q <= 1'b0;
			reclaim_q <= `ZERO_CNT;
			ctx_dead_q <= 1'b0;
			unrecoverable_evt_q <= 1'b0;
			pkt_done_evt_q <= 1'b0;
			resp_conflict_q <= 1'b0;
			posted_err_q <= 1'b0;
			err_src_q <= 16'h0000;
			err_off_q <= 48'h0000_0000_0000;
		end else begin
			reclaim_valid_q <= 1'b0;
			unrecoverable_evt_q <= 1'b0;
			pkt_done_evt_q <= 1'b0;
			resp_conflict_q <= 1'b0;
			posted_err_q <= 1'b0;
			// dead only while run stays set
			if (!run_ctl)
				ctx_dead_q <= 1'b0;
			else if (write_fail && !ctx_dead_q) begin
				ctx_dead_q <= 1'b1;
				unrecoverable_evt_q <= 1'b1;
			end
			if (pop) begin
				// counter restarts with each packet
				sys_cnt_q <= head_last ? `ZERO_CNT : sys_cnt_q + 1'b1;
				wi_q <= head_last ? 2'h0 : (wi_q == `WI_MAX ? wi_q : wi_q + 1'b1);
				if (wi_q == 2'h0)
					rd_pkt_q <= !is_write(head[31:0]);
				// failure info survives until a clean packet lands
				if (wi_q == 2'h1 && !hold_q) begin
					err_src_q <= head[`SRC_HI:`SRC_LO];
					err_off_q[47:32] <= head[`OFFHI_HI:`OFFHI_LO];
				end
				if (wi_q == 2'h2 && !hold_q) begin
					err_off_q[31:0] <= head[31:0];
					hold_q <= 1'b1;
				end
				if (head_last && !ctx_dead_q) begin
					if (head_err && head_req) begin
						reclaim_valid_q <= 1'b1;
						reclaim_q <= sys_cnt_q + 1'b1;
					end else if (!head_err) begin
						hold_q <= 1'b0;
						pkt_done_evt_q <= 1'b1;
					end
				end
				if (head_last && ctx_dead_q && head[`TAG_CLS_HI:`TAG_CLS_LO] != `CLS_RESP) begin
					if (rd_pkt_q)
						resp_conflict_q <= 1'b1;
					else if (head[`ACK_HI:`ACK_LO] == `ACK_PENDING)
						resp_conflict_q <= 1'b1;
					else if (head[`ACK_HI:`ACK_LO] == `ACK_COMPLETE &&
							err_off_q[47:32] < `PHYS_LIMIT_HI)
						posted_err_q <= 1'b1;
				end
			end
		end
	end
endmodule // async_receive_request_fifo

// ### tb/arq_fifo_props.sv
// port-level assertions for the receive request fifo
// assumes binding into the top module; one clock, async reset
module arq_fifo_props (
	input wire core_clk,
	input wire rst,
	input wire run_ctl,
	input wire link_valid,
	input wire link_ready,
	input wire link_first,
	input wire link_last,
	input wire [2:0] link_kind,
	input wire write_fail,
	input wire desc_len_valid,
	input wire space_add_valid,
	input wire ack_busy_q,
	input wire dma_valid,
	input wire dma_ready,
	input wire [31:0] dma_data,
	input wire dma_last,
	input wire dma_err,
	input wire ctx_dead_q,
	input wire unrecoverable_evt_q,
	input wire pkt_done_evt_q,
	input wire resp_conflict_q,
	input wire phys_req_valid_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// =====================================================
	// helpers
	wire acc = link_valid && link_ready;
	wire req1 = acc && link_first && link_kind == 3'h0;
	wire adds = desc_len_valid || space_add_valid;
	sequence halted;
		!run_ctl [*2];
	endsequence
	sequence failed;
		write_fail ##1 (!adds && req1);
	endsequence
	sequence lone_req_kept;
		acc && link_first && link_last && link_kind == 3'h0 ##1 !ack_busy_q;
	endsequence
	// =====================================================
	// checks
	a_halt_busies: assert property (halted ##0 req1 |=> ack_busy_q)
		else $error("request not busied while halted");
	a_fail_busies: assert property (failed |=> ack_busy_q)
		else $error("request not busied after failure");
	a_trailer_slot: assert property (lone_req_kept |-> !link_ready)
		else $error("no trailer slot after packet end");
	a_err_ends: assert property (dma_valid && dma_err |-> dma_last)
		else $error("error entry not last");
	a_dma_holds: assert property (dma_valid && !dma_ready |=>
		dma_valid && $stable(dma_data) && $stable({dma_last, dma_err}))
		else $error("stalled entry changed");
	a_unrec_evt: assert property (run_ctl && write_fail && !ctx_dead_q
		|-> ##[1:2] unrecoverable_evt_q)
		else $error("no unrecoverable event");
	a_done_quiet: assert property (ctx_dead_q [*3] |-> !pkt_done_evt_q)
		else $error("completion event while dead");
	a_conflict_dead: assert property (resp_conflict_q |-> $past(ctx_dead_q))
		else $error("conflict response while alive");
	a_phys_bypass: assert property (acc && link_first && link_kind == 3'h2
		|-> ##[1:2] phys_req_valid_q)
		else $error("physical read not bypassed");
endmodule // arq_fifo_props

bind async_receive_request_fifo arq_fifo_props props_i (.*);

// ### tb/dma_sink.sv
// model of the host-memory dma writer behind the two-slot buffer
// assumes the bench reads and clears the got queue by hierarchy
module dma_sink (
	input wire core_clk,
	input wire rst,
	input wire [1:0] sink_mode,
	input wire dma_valid,
	input wire [31:0] dma_data,
	input wire dma_last,
	input wire dma_err,
	output logic dma_ready = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [33:0] got[$];
	logic [1:0] ph = 2'h0;
	// mode 0 prompt, 1 one cycle in four, 2 stalled; moves off the sampling edge
	always @(negedge core_clk) begin
		ph <= ph + 2'h1;
		dma_ready <= !rst && (sink_mode == 2'h0 || (sink_mode == 2'h1 && ph == 2'h0));
	end
	// an entry counts only at an edge where valid and ready are both high
	always @(posedge core_clk)
		if (dma_valid === 1'b1 && dma_ready === 1'b1)
			got.push_back({dma_err, dma_last, dma_data});
endmodule // dma_sink

// ### tb/async_receive_request_fifo_tb_top.sv
// self-checking bench for the receive request fifo
// assumes dma_sink and the bound checker are compiled first
module async_receive_request_fifo_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst = 1, run_ctl = 0, link_valid = 0, link_first = 0;
	logic link_last = 0, link_crc_err = 0, node_self_identify_phase = 0, node_self_identify_accept_en = 0;
	logic resp_space_ok = 0, desc_len_valid = 0, space_add_valid = 0, write_fail = 0;
	logic [31:0] link_data = 32'h0;
	logic [2:0] link_kind = 3'h0, link_speed = 3'h2;
	logic [3:0] sent_acknowledge_code = 4'h1;
	logic [15:0] receive_cycle_stamp = 16'hBEEF;
	logic [13:0] descriptor_buffer_length = 14'h0, space_add_len = 14'h0;
	logic [1:0] sink_mode = 2'h0;
	wire link_ready, ack_busy_q, phys_req_valid_q, node_self_identify_valid_q, dma_valid, dma_last;
	wire dma_err, dma_ready, ctx_dead_q, unrecoverable_evt_q, pkt_done_evt_q;
	wire resp_conflict_q, posted_err_q;
	wire [31:0] phys_req_data_q, node_self_identify_data_q, dma_data;
	wire [15:0] err_src_q;
	wire [47:0] err_off_q;
	int bad_count = 0, total_checks = 0, cyc = 0, b, c, p, s, u;
	int busy_n = 0, conf_n = 0, post_n = 0, unrec_n = 0, phys_n = 0, sid_n = 0;

	async_receive_request_fifo #(.DEPTH(16), .AW(4)) uut (.*);
	dma_sink sink (.*);

	initial forever #50 core_clk = ~core_clk;
	// event pulses tallied mid-cycle, where they have settled
	always @(negedge core_clk) begin
		busy_n += ack_busy_q;
		conf_n += resp_conflict_q;
		post_n += posted_err_q;
		unrec_n += unrecoverable_evt_q;
		phys_n += phys_req_valid_q;
		sid_n += node_self_identify_valid_q;
	end
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	// =====================================================
	// shared tasks
	function automatic logic [31:0] qd(input logic [3:0] tc, input int i);
		return (i == 0) ? {24'h5A0000, tc, 4'h0} : 32'h1234_0000 + i - 1;
	endfunction
	function automatic logic [33:0] tr(input logic [3:0] ack, input logic crc);
		return {crc, 1'b1, ack, 1'b0, link_speed, 8'h00, receive_cycle_stamp};
	endfunction
	task automatic cmp_w(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_n(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pop_w(input logic [33:0] exp);
		logic [33:0] w;
		w = ~exp;
		for (int i = 0; i < 300 && sink.got.size() == 0; i++) @(negedge core_clk);
		if (sink.got.size() > 0) w = sink.got.pop_front();
		cmp_w(w, exp);
	endtask
	// called at a falling edge; each quadlet held until link_ready takes it
	task automatic send(input logic [2:0] k, input logic [3:0] tc, input int n,
		input logic crc, input logic [3:0] ack);
		for (int i = 0; i < n; i++) begin
			link_valid = 1;
			link_first = (i == 0);
			link_last = (i == n - 1);
			link_data = qd(tc, i);
			link_kind = k;
			link_crc_err = crc;
			sent_acknowledge_code = ack;
			while (link_ready !== 1'b1) @(negedge core_clk);
			@(negedge core_clk);
		end
		// one idle edge so a following call never re-raises valid in this step
		link_valid = 0;
		@(negedge core_clk);
	endtask
	// run toggled low first so each scenario starts from an empty counter
	task automatic fresh(input logic [13:0] dl, input logic [13:0] sl);
		run_ctl = 0;
		repeat (2) @(negedge core_clk);
		run_ctl = 1;
		@(negedge core_clk);
		descriptor_buffer_length = dl;
		desc_len_valid = (dl != 0);
		space_add_len = sl;
		space_add_valid = (sl != 0);
		@(negedge core_clk);
		desc_len_valid = 0;
		space_add_valid = 0;
		sink.got.delete();
		b = busy_n;
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// =====================================================
	// scenarios
	task automatic t_halted();
		b = busy_n;
		send(3'h0, 4'h1, 1, 0, 4'h1);
		repeat (4) @(negedge core_clk);
		cmp_n(busy_n, b + 1);
		cmp_n(sink.got.size(), 0);
	endtask
	task automatic t_credit();
		fresh(14'h2, 14'h2);
		sink_mode = 2'h1;
		send(3'h0, 4'h1, 2, 0, 4'h1);
		pop_w({2'b00, qd(4'h1, 0)});
		pop_w({2'b00, qd(4'h1, 1)});
		pop_w(tr(4'h1, 0));
		cmp_n(busy_n, b);
		sink_mode = 2'h0;
	endtask
	task automatic t_marker();
		fresh(14'h0, 14'h2);
		send(3'h0, 4'h1, 3, 0, 4'h1);
		pop_w({2'b00, qd(4'h1, 0)});
		pop_w({2'b11, 32'hFFFF_FFFF});
		repeat (6) @(negedge core_clk);
		cmp_n(busy_n, b + 1);
		cmp_n(sink.got.size(), 0);
	endtask
	task automatic t_backout();
		fresh(14'h3, 14'h0);
		send(3'h0, 4'h1, 1, 1, 4'h1);
		pop_w({2'b00, qd(4'h1, 0)});
		pop_w(tr(4'h1, 1));
		repeat (10) @(negedge core_clk);
		send(3'h0, 4'h1, 2, 0, 4'h1);
		pop_w({2'b00, qd(4'h1, 0)});
		pop_w({2'b00, qd(4'h1, 1)});
		pop_w(tr(4'h1, 0));
		cmp_n(busy_n, b);
	endtask
	task automatic t_bypass();
		fresh(14'h0, 14'h2);
		p = phys_n;
		s = sid_n;
		send(3'h2, 4'h4, 1, 0, 4'h2);
		node_self_identify_phase = 1;
		node_self_identify_accept_en = 1;
		send(3'h4, 4'h0, 1, 0, 4'h1);
		node_self_identify_phase = 0;
		send(3'h3, 4'h2, 1, 0, 4'h1);
		send(3'h0, 4'h1, 1, 0, 4'h1);
		send(3'h1, 4'h1, 3, 0, 4'h1);
		repeat (20) @(negedge core_clk);
		cmp_n(phys_n, p + 1);
		cmp_n(sid_n, s + 1);
		cmp_n(busy_n, b);
		cmp_n(sink.got.size(), 6);
	endtask
	task automatic t_dead();
		fresh(14'hC, 14'h0);
		sink_mode = 2'h2;
		c = conf_n;
		p = post_n;
		u = unrec_n;
		send(3'h0, 4'h4, 3, 0, 4'h2);
		send(3'h0, 4'h1, 3, 0, 4'h2);
		send(3'h0, 4'h1, 3, 0, 4'h1);
		write_fail = 1;
		desc_len_valid = 1;
		@(negedge core_clk);
		write_fail = 0;
		desc_len_valid = 0;
		send(3'h0, 4'h1, 1, 0, 4'h1);
		sink_mode = 2'h0;
		repeat (40) @(negedge core_clk);
		cmp_n(busy_n, b + 1);
		cmp_n(ctx_dead_q, 1);
		cmp_n(unrec_n, u + 1);
		cmp_n(conf_n, c + 2);
		cmp_n(post_n, p + 1);
		cmp_n(err_src_q, 32'h1234);
		cmp_n(err_off_q[31:0], 32'h1234_0001);
		cmp_n(err_off_q[47:32], 32'h0000_0000);
		run_ctl = 0;
		repeat (2) @(negedge core_clk);
		cmp_n(ctx_dead_q, 0);
	endtask
	// =====================================================
	// main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		rst = 0;
		repeat (2) @(negedge core_clk);
		t_halted();
		t_credit();
		t_marker();
		t_backout();
		t_bypass();
		t_dead();
		wrap_up();
	end
endmodule // async_receive_request_fifo_tb_top
